// >>> hw/call_progress_pwm_out.sv
// call-progress monitor output: attenuates, sums and modulates the
// transmit and receive voice paths onto one digital pin
// assumes samples and register strobes come from core_clk logic
`timescale 1ns/10ps
module call_progress_pwm_out
  import call_progress_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [7:0]         reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic      [7:0]         reg_rdata,
  input  wire logic signed [15:0] tx_sample,
  input  wire logic signed [15:0] rx_sample,
  input  wire logic               sample_valid,
  output logic                    monitor_audio_pin,
  output logic                    monitor_audio_oe
);
  import call_progress_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]         rx_atten;
    logic [7:0]         tx_atten;
    logic               tone_en;
    tone_format_t       format;
    logic               int_en;
    logic [7:0]         rdata;
    logic signed [16:0] level;
    logic [11:0]        cnt;
    logic [11:0]        duty;
    logic [15:0]        acc;
    logic               pin;
    logic               oe;
  } state_t;

  state_t             cur;
  state_t             next_s;
  logic signed [15:0] rx_scaled;
  logic signed [15:0] tx_scaled;
  logic signed [16:0] sum;
  logic        [16:0] level_u;
  logic        [23:0] duty_prod;
  logic        [16:0] acc_sum;
  logic        [11:0] bal_lo;
  logic        [11:0] bal_hi;
  logic               active;
  logic               wave;

  // ----------------------------------------------------------------
  // attenuation stages
  // ----------------------------------------------------------------
  // the stages only tap the voice samples; the line paths are untouched
  monitor_attenuator u_rx_atten (
    .sample (rx_sample),
    .gain   (cur.rx_atten),
    .scaled (rx_scaled)
  );

  monitor_attenuator u_tx_atten (
    .sample (tx_sample),
    .gain   (cur.tx_atten),
    .scaled (tx_scaled)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = cur;

    // register writes
    if (reg_write) begin
      unique case (reg_addr)
        ADDR_RX_ATTEN: next_s.rx_atten = reg_wdata;
        ADDR_TX_ATTEN: next_s.tx_atten = reg_wdata;
        ADDR_TONE_CTRL: begin
          next_s.tone_en = reg_wdata[TONE_EN_BIT];
          next_s.format  =
            tone_format_t'(reg_wdata[FORMAT_LSB +: 2]);
        end
        ADDR_PIN_CTRL: next_s.int_en = reg_wdata[INT_EN_BIT];
        default: ;
      endcase
    end

    // register reads, data valid in the following cycle only
    next_s.rdata = 8'h00;
    if (reg_read) begin
      unique case (reg_addr)
        ADDR_RX_ATTEN: next_s.rdata = cur.rx_atten;
        ADDR_TX_ATTEN: next_s.rdata = cur.tx_atten;
        ADDR_TONE_CTRL: begin
          next_s.rdata[TONE_EN_BIT]     = cur.tone_en;
          next_s.rdata[FORMAT_LSB +: 2] = cur.format;
        end
        ADDR_PIN_CTRL: next_s.rdata[INT_EN_BIT] = cur.int_en;
        ADDR_MON_STATUS: next_s.rdata = {6'h00, cur.pin, cur.oe};
        default: next_s.rdata = 8'h00;
      endcase
    end

    // sum of both attenuated paths, 17 bits so it never overflows
    sum = 17'(rx_scaled) + 17'(tx_scaled);
    if (sample_valid)
      next_s.level = sum;

    // offset binary copy of the level for the modulators
    level_u = {~cur.level[16], cur.level[15:0]};

    // 32 kHz frame counter; duty is sampled once per frame so a new
    // level never splits a pulse
    duty_prod = level_u[16:5] * PWM_PERIOD;
    if (cur.cnt == PWM_PERIOD - 12'h001) begin
      next_s.cnt  = 12'h000;
      next_s.duty = duty_prod[23:12];
    end else begin
      next_s.cnt = cur.cnt + 12'h001;
    end

    // first order delta-sigma: the carry is the output bit
    acc_sum = {1'b0, cur.acc} + {1'b0, level_u[16:1]};
    next_s.acc = acc_sum[15:0];

    // balanced pulse is centred in the frame
    bal_lo = PWM_HALF - {1'b0, cur.duty[11:1]};
    bal_hi = bal_lo + cur.duty;

    wave = 1'b0;
    unique case (cur.format)
      FMT_RZ_PWM:       wave = cur.cnt < cur.duty;
      FMT_BALANCED_PWM:
        wave = (cur.cnt >= bal_lo) && (cur.cnt < bal_hi);
      FMT_DELTA_SIGMA:  wave = acc_sum[16];
      FMT_RESERVED:     wave = 1'b0;
    endcase

    // the pin is shared with the interrupt output, which wins
    active    = cur.tone_en && !cur.int_en;
    next_s.oe  = active;
    next_s.pin = active && wave;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur          <= '0;
      cur.rx_atten <= ATTEN_RESET;
      cur.tx_atten <= ATTEN_RESET;
      cur.tone_en  <= TONE_EN_RESET;
      cur.format   <= tone_format_t'(FORMAT_RESET);
      cur.int_en   <= INT_EN_RESET;
    end else begin
      cur <= next_s;
    end
  end

  assign reg_rdata         = cur.rdata;
  assign monitor_audio_pin = cur.pin;
  assign monitor_audio_oe  = cur.oe;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  a_rx_atten_read: assert property (
    reg_write && reg_addr == ADDR_RX_ATTEN ##1
    reg_read && reg_addr == ADDR_RX_ATTEN
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("rx attenuation readback wrong");

  a_both_muted: assert property (
    cur.rx_atten == 8'h00 && cur.tx_atten == 8'h00 && sample_valid
    && !reg_write |=> cur.level == 17'sd0)
    else $error("muted paths left a level");

  a_sum_taken: assert property (
    sample_valid |=> cur.level == $past(sum))
    else $error("monitor sum not captured");

  a_format_store: assert property (
    reg_write && reg_addr == ADDR_TONE_CTRL
    |=> cur.format == $past(reg_wdata[5:4]))
    else $error("format field not stored");

  a_frame_wrap: assert property (
    cur.cnt == PWM_PERIOD - 12'h001 |=> cur.cnt == 12'h000 ##1
    cur.cnt == 12'h001)
    else $error("frame counter does not wrap at 32 kHz");

  a_rz_start: assert property (
    active && cur.format == FMT_RZ_PWM && cur.cnt == 12'h000
    && cur.duty != 12'h000 |=> monitor_audio_pin)
    else $error("return-to-zero pulse missing at frame start");

  a_rz_return: assert property (
    cur.format == FMT_RZ_PWM && cur.cnt >= cur.duty
    |=> !monitor_audio_pin)
    else $error("return-to-zero pulse too long");

  a_bal_centre: assert property (
    cur.format == FMT_BALANCED_PWM && cur.cnt < bal_lo
    |=> !monitor_audio_pin)
    else $error("balanced pulse starts early");

  a_pin_idle: assert property (
    !cur.tone_en |=> !monitor_audio_oe && !monitor_audio_pin)
    else $error("pin driven while tone output disabled");

  // a write in the same cycle may clear the enable, so only a quiet
  // bus guarantees the pin stays released for two more cycles
  a_int_blocks: assert property (
    cur.int_en && !reg_write |=> !monitor_audio_oe [*2])
    else $error("pin driven while interrupt enabled");

  c_rz_pulse: cover property (
    active && cur.format == FMT_RZ_PWM ##1 monitor_audio_pin);
  c_bal_pulse: cover property (
    active && cur.format == FMT_BALANCED_PWM ##1 monitor_audio_pin);
  c_ds_bit: cover property (
    active && cur.format == FMT_DELTA_SIGMA ##1 monitor_audio_pin);
endmodule

// >>> hw/call_progress_pkg.sv
// constants shared by the call-progress monitor output block
// assumes a 100 MHz core clock and an 8-bit register address port
package call_progress_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TONE_CTRL   = 8'h01;
  localparam logic [7:0] ADDR_PIN_CTRL    = 8'h02;
  localparam logic [7:0] ADDR_MON_STATUS  = 8'h03;
  localparam logic [7:0] ADDR_RX_ATTEN    = 8'h14;
  localparam logic [7:0] ADDR_TX_ATTEN    = 8'h15;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         TONE_EN_BIT      = 3;
  localparam int         FORMAT_LSB       = 4;
  localparam int         INT_EN_BIT       = 0;
  localparam logic [7:0] ATTEN_RESET      = 8'h00;
  localparam logic [1:0] FORMAT_RESET     = 2'h0;
  localparam logic       TONE_EN_RESET    = 1'b0;
  localparam logic       INT_EN_RESET     = 1'b0;

  typedef enum logic [1:0] {
    FMT_RZ_PWM       = 2'b00,
    FMT_BALANCED_PWM = 2'b01,
    FMT_DELTA_SIGMA  = 2'b10,
    FMT_RESERVED     = 2'b11
  } tone_format_t;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_HZ           = 100_000_000;
  localparam int         PWM_RATE_HZ      = 32_000;
  localparam int         PWM_PERIOD_INT   = CLK_HZ / PWM_RATE_HZ;
  localparam logic [11:0] PWM_PERIOD      = PWM_PERIOD_INT[11:0];
  localparam logic [11:0] PWM_HALF        = PWM_PERIOD_INT[12:1];

endpackage

// >>> hw/monitor_attenuator.sv
// one linear attenuation stage for a monitor voice path
// assumes a two's complement sample and an unsigned gain of n/256
`timescale 1ns/10ps
module monitor_attenuator (
  input  wire logic signed [15:0] sample,
  input  wire logic        [7:0]  gain,
  output logic signed      [15:0] scaled
);
  logic signed [24:0] product;

  // a gain of zero gives an exact zero product, so the path is muted
  always_comb begin
    product = sample * $signed({1'b0, gain});
    scaled  = product[23:8];
  end
endmodule

// >>> test/speaker_drive_model.sv
// speaker driver model: measures the pulse train on the monitor pin
// assumes one core_clk domain; an undriven pin reads low (pull-down)
`timescale 1ns/10ps
module speaker_drive_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        pin,
  input  wire logic        oe,
  output logic      [15:0] period,
  output logic      [15:0] high_len
);
  logic        base;
  logic        last;
  logic [15:0] run;
  logic [15:0] hi;
  // the transistor base sees nothing while the pin is released
  assign base = oe & pin;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {last, run, hi, period, high_len} <= '0;
    end else begin
      last <= base;
      run  <= (base & !last) ? 16'h0001 : run + 16'h0001;
      hi   <= base ? hi + 16'h0001 : 16'h0000;
      if (base & !last) period <= run;
      if (!base & last) high_len <= hi;
    end
  end
endmodule

// >>> test/call_progress_pwm_out_tb.sv
// self-checking bench for the call-progress monitor output
// assumes the frame length and register map of the package
`timescale 1ns/10ps
module call_progress_pwm_out_tb;
  import call_progress_pkg::*;
  logic               core_clk     = 1'b0;
  logic               rst_n        = 1'b0;
  logic        [7:0]  reg_addr     = 8'h00;
  logic        [7:0]  reg_wdata    = 8'h00;
  logic               reg_write    = 1'b0;
  logic               reg_read     = 1'b0;
  logic        [7:0]  reg_rdata;
  logic signed [15:0] tx_sample    = 16'h0000;
  logic signed [15:0] rx_sample    = 16'h0000;
  logic               sample_valid = 1'b0;
  logic               monitor_audio_pin;
  logic               monitor_audio_oe;
  logic        [15:0] period;
  logic        [15:0] high_len;
  logic        [16:0] o;
  logic        [31:0] dty;
  int                 errors       = 0;
  int                 tests_run    = 0;
  int                 cycles       = 0;
  int                 ones;
  integer             seed         = 32'ha740;

  always #5 core_clk = ~core_clk;

  call_progress_pwm_out call_progress_pwm_out_i (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .reg_addr          (reg_addr),
    .reg_wdata         (reg_wdata),
    .reg_write         (reg_write),
    .reg_read          (reg_read),
    .reg_rdata         (reg_rdata),
    .tx_sample         (tx_sample),
    .rx_sample         (rx_sample),
    .sample_valid      (sample_valid),
    .monitor_audio_pin (monitor_audio_pin),
    .monitor_audio_oe  (monitor_audio_oe)
  );
  speaker_drive_model speaker_drive_model_i (.core_clk(core_clk),
    .rst_n(rst_n), .pin(monitor_audio_pin), .oe(monitor_audio_oe),
    .period(period), .high_len(high_len));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic complete_run;
    if (errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp,
                     input int tol);
    tests_run++;
    if ((^got === 1'bx) || (got > exp + tol) || (got + tol < exp)) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    @(negedge core_clk);
    cmp({8'h00, reg_rdata}, {8'h00, exp}, 0);
    // read data stand for one cycle only, zero afterwards
    @(negedge core_clk);
    cmp({8'h00, reg_rdata}, 16'h0000, 0);
  endtask

  // write followed by a read of the same register with no gap
  task automatic wrrd(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge core_clk);
    reg_read  <= 1'b0;
    @(negedge core_clk);
    cmp({8'h00, reg_rdata}, {8'h00, d}, 0);
  endtask

  // offset level: signed sum of the scaled paths moved to unsigned
  function automatic logic [16:0] offs(input logic [7:0] ra, ta,
                                       input logic signed [15:0] rx, tx);
    logic signed [31:0] l;
    l = ((rx * $signed({1'b0, ra})) >>> 8)
      + ((tx * $signed({1'b0, ta})) >>> 8);
    return l[16:0] + 17'h10000;
  endfunction

  task automatic play(input logic [7:0] ra, input logic [7:0] ta,
                      input int frames);
    wr(ADDR_RX_ATTEN, ra);
    wr(ADDR_TX_ATTEN, ta);
    rd(ADDR_RX_ATTEN, ra);
    rd(ADDR_TX_ATTEN, ta);
    @(posedge core_clk);
    rx_sample    <= 16'($random(seed));
    tx_sample    <= 16'($random(seed));
    sample_valid <= 1'b1;
    @(posedge core_clk);
    sample_valid <= 1'b0;
    o   = offs(ra, ta, rx_sample, tx_sample);
    dty = ({20'h0, o[16:5]} * 32'd3125) >> 12;
    // new duty needs a wrap, then two whole frames to be measured
    repeat (frames * PWM_PERIOD_INT) @(posedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(ADDR_RX_ATTEN, ATTEN_RESET);
    rd(ADDR_TONE_CTRL, 8'h00);
    rd(8'h40, 8'h00);
    wrrd(ADDR_RX_ATTEN, 8'($random(seed)));
    cmp({15'h0, monitor_audio_oe}, 16'h0, 0);
    wr(ADDR_PIN_CTRL, 8'h01);
    wr(ADDR_TONE_CTRL, 8'h08);
    repeat (2) @(negedge core_clk);
    cmp({14'h0, monitor_audio_oe, monitor_audio_pin}, 16'h0, 0);
    wr(ADDR_PIN_CTRL, 8'h00);
    repeat (2) @(negedge core_clk);
    cmp({15'h0, monitor_audio_oe}, 16'h1, 0);
    for (int f = 0; f < 2; f++) begin
      wr(ADDR_TONE_CTRL, {2'b00, 2'(f), 4'h8});
      play(8'h00, 8'h00, 3);
      cmp(high_len, 16'd1562, 0);
      play(8'hff, 8'($random(seed)), 3);
      cmp(high_len, dty[15:0], 0);
      play(8'($random(seed)) & 8'h7f, 8'hff, 3);
      cmp(high_len, dty[15:0], 0);
      cmp(period, 16'd3125, 0);
    end
    wr(ADDR_TONE_CTRL, 8'h28);
    play(8'($random(seed)), 8'($random(seed)), 1);
    ones = 0;
    repeat (4096) begin
      @(negedge core_clk);
      ones += monitor_audio_pin;
    end
    cmp(16'(ones), {4'h0, o[16:5]}, 2);
    wr(ADDR_TONE_CTRL, 8'h38);
    // the last delta-sigma bit still stands for one clock
    @(negedge core_clk);
    ones = 0;
    repeat (PWM_PERIOD_INT) begin
      @(negedge core_clk);
      ones += monitor_audio_pin;
    end
    cmp(16'(ones), 16'h0, 0);
    cmp({15'h0, monitor_audio_oe}, 16'h1, 0);
    complete_run();
  end
endmodule
